// ---- sptr_motor_model.sv ----
// Stand-in for the two bridge stages and the motor windings.
// Assumes winding and gate levels come straight from the translator pins.
`timescale 1ns/1ps
`default_nettype none
module sptr_motor_model (
    input wire logic [3:0] winding,
    input wire logic [1:0] bridge_gate,
    output logic [1:0] coils_on,
    output logic shoot_through
);
    // A bridge carries current only when gated and one leg is driven
    logic bridge_a_on;
    logic bridge_b_on;
    assign bridge_a_on = bridge_gate[1] & (winding[3] | winding[2]);
    assign bridge_b_on = bridge_gate[0] & (winding[1] | winding[0]);
    assign coils_on = {1'b0, bridge_a_on} + {1'b0, bridge_b_on};
    // Both legs high would short the supply through the bridge
    assign shoot_through = (bridge_gate[1] & winding[3] & winding[2])
        | (bridge_gate[0] & winding[1] & winding[0]);
endmodule : sptr_motor_model
`default_nettype wire

// ---- sptr_pkg.sv ----
// Shared constants, register map and carriers for the stepper translator.
// Assumes a single 50 MHz clock domain and an AXI4-Lite register bus.
package sptr_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
    localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
    localparam logic [3:0] ADDR_LSB_MASK = 4'hc;
    localparam int unsigned CTRL_W = 6;
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned CTRL_DIR_BIT = 1;
    localparam int unsigned CTRL_HALF_BIT = 2;
    localparam int unsigned CTRL_COMP_BIT = 3;
    localparam int unsigned CTRL_SRST_BIT = 4;
    localparam int unsigned CTRL_STEP_BIT = 5;
    // Status word: [2:0] state, [6:3] windings 1..4, [8:7] gates, 9 home,
    // 10 reduced reference
    localparam int unsigned STAT_STATE_POS = 0;
    localparam int unsigned STAT_WIND_POS = 3;
    localparam int unsigned STAT_GATE_POS = 7;
    localparam int unsigned STAT_HOME_POS = 9;
    localparam int unsigned STAT_REF_POS = 10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] HOME_PATTERN = 4'h5;
    localparam logic [2:0] HOME_STATE = 3'h0;
    localparam logic [2:0] HALF_STRIDE = 3'h1;
    localparam logic [2:0] FULL_STRIDE = 3'h2;

    // Control register carrier; bit 0 is enable
    typedef struct packed {
        logic step;
        logic seq_reset;
        logic torque_comp_select;
        logic half_select;
        logic direction_select;
        logic enable;
    } sptr_ctrl_t;

    // Pull-up on compensation select shows as its reset value
    localparam sptr_ctrl_t CTRL_RESET = '{step: 1'b0, seq_reset: 1'b0,
        torque_comp_select: 1'b1, half_select: 1'b0,
        direction_select: 1'b1, enable: 1'b1};

    typedef struct packed {
        logic ref_reduced;
        logic home;
        logic [1:0] bridge_gate;
        logic [3:0] winding;
    } sptr_drive_t;

    // Winding pattern {w1,w2,w3,w4} for state index 0..7 (states 1..8)
    function automatic logic [3:0] phase_pattern(input logic [2:0] idx);
        logic [3:0] p;
        p = HOME_PATTERN;
        unique case (idx)
            3'h0: p = 4'h5;
            3'h1: p = 4'h1;
            3'h2: p = 4'h9;
            3'h3: p = 4'h8;
            3'h4: p = 4'ha;
            3'h5: p = 4'h2;
            3'h6: p = 4'h6;
            3'h7: p = 4'h4;
        endcase
        return p;
    endfunction : phase_pattern
endpackage : sptr_pkg

// ---- sptr_top.sv ----
// Stepper phase translator with an AXI4-Lite register slave.
// Assumes one 50 MHz clock; driver stages sit on the winding/gate outputs.
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sptr_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic winding_drive_1,
    output logic winding_drive_2,
    output logic winding_drive_3,
    output logic winding_drive_4,
    output logic bridge_gate_1,
    output logic bridge_gate_2,
    output logic home_flag,
    output logic ref_reduced
);
    // Write address/data holding
    logic aw_got_q;
    logic aw_got_d;
    logic w_got_q;
    logic w_got_d;
    logic [31:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic awready_q;
    logic awready_d;
    logic wready_q;
    logic wready_d;
    logic bvalid_q;
    logic bvalid_d;
    logic [1:0] bresp_q;
    logic [1:0] bresp_d;
    // Read side
    logic arready_q;
    logic arready_d;
    logic rvalid_q;
    logic rvalid_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0] rresp_q;
    logic [1:0] rresp_d;
    // Control state
    sptr_pkg::sptr_ctrl_t ctrl_q;
    sptr_pkg::sptr_ctrl_t ctrl_d;
    logic step_prev_q;
    logic step_pulse;
    logic [2:0] state_q;
    sptr_pkg::sptr_drive_t drive_q;

    logic aw_take;
    logic w_take;
    logic ar_take;
    logic wr_fire;
    logic wr_ctrl_hit;
    logic wr_stat_hit;
    logic rd_ctrl_hit;
    logic rd_stat_hit;
    logic [31:0] ctrl_word;
    logic [31:0] status_word;

    assign aw_take = s_axi_awvalid & awready_q;
    assign w_take = s_axi_wvalid & wready_q;
    assign ar_take = s_axi_arvalid & arready_q;
    // Commit only once both halves are held and no response is pending
    assign wr_fire = aw_got_q & w_got_q & ~bvalid_q;

    assign wr_ctrl_hit = (awaddr_q[31:4] == sptr_pkg::CTRL_OFFSET[31:4])
        && ((awaddr_q[3:0] & sptr_pkg::ADDR_LSB_MASK)
            == sptr_pkg::CTRL_OFFSET[3:0]);
    assign wr_stat_hit = (awaddr_q[31:4] == sptr_pkg::STATUS_OFFSET[31:4])
        && ((awaddr_q[3:0] & sptr_pkg::ADDR_LSB_MASK)
            == sptr_pkg::STATUS_OFFSET[3:0]);
    assign rd_ctrl_hit = (s_axi_araddr[31:4] == sptr_pkg::CTRL_OFFSET[31:4])
        && ((s_axi_araddr[3:0] & sptr_pkg::ADDR_LSB_MASK)
            == sptr_pkg::CTRL_OFFSET[3:0]);
    assign rd_stat_hit =
        (s_axi_araddr[31:4] == sptr_pkg::STATUS_OFFSET[31:4])
        && ((s_axi_araddr[3:0] & sptr_pkg::ADDR_LSB_MASK)
            == sptr_pkg::STATUS_OFFSET[3:0]);

    assign aw_got_d = wr_fire ? 1'b0 : (aw_got_q | aw_take);
    assign w_got_d = wr_fire ? 1'b0 : (w_got_q | w_take);
    assign bvalid_d = wr_fire | (bvalid_q & ~s_axi_bready);
    assign awready_d = ~aw_got_d & ~bvalid_d;
    assign wready_d = ~w_got_d & ~bvalid_d;
    // Status is read-only; a write there is refused like an unmapped one
    assign bresp_d = wr_fire ? (wr_ctrl_hit ? sptr_pkg::RESP_OKAY
                                            : sptr_pkg::RESP_SLVERR)
                             : bresp_q;

    // A second write is refused until the pending answer is taken
    AST_WR_READY_LOW: assert property (@(posedge aclk)
        disable iff (!aresetn)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write ready high while a response is pending");
    AST_BRESP_HOLD: assert property (@(posedge aclk)
        disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response changed before it was taken");
    // Status is read-only, so a write there must not touch control
    AST_STAT_WR_REFUSED: assert property (@(posedge aclk)
        disable iff (!aresetn)
        wr_fire && wr_stat_hit
        |=> s_axi_bresp == sptr_pkg::RESP_SLVERR && $stable(ctrl_q))
        else $error("status write was not refused");
    AST_UNMAPPED_WR: assert property (@(posedge aclk)
        disable iff (!aresetn)
        wr_fire && !wr_ctrl_hit && !wr_stat_hit
        |=> s_axi_bresp == sptr_pkg::RESP_SLVERR && $stable(ctrl_q))
        else $error("unmapped write was not refused");

    // Only byte lane 0 carries control bits
    assign ctrl_d = (wr_fire && wr_ctrl_hit && wstrb_q[0])
        ? sptr_pkg::sptr_ctrl_t'(wdata_q[sptr_pkg::CTRL_W-1:0]) : ctrl_q;

    AST_CTRL_WRITE: assert property (@(posedge aclk)
        disable iff (!aresetn)
        wr_fire && wr_ctrl_hit && wstrb_q[0]
        |=> {26'h0, ctrl_q} == ($past(wdata_q) & 32'h0000_003f)
            && s_axi_bresp == sptr_pkg::RESP_OKAY)
        else $error("control write did not land");
    // Without lane 0 nothing lands, yet the write is still answered OKAY
    AST_CTRL_NO_LANE: assert property (@(posedge aclk)
        disable iff (!aresetn)
        wr_fire && wr_ctrl_hit && !wstrb_q[0]
        |=> $stable(ctrl_q) && s_axi_bresp == sptr_pkg::RESP_OKAY)
        else $error("control write without lane 0 had an effect");

    // Software step edge is a 0 to 1 change of the step bit
    assign step_pulse = ctrl_q.step & ~step_prev_q;

    assign ctrl_word = {26'h0, ctrl_q};
    assign status_word = {21'h0, drive_q.ref_reduced, drive_q.home,
                          drive_q.bridge_gate, drive_q.winding, state_q};
    assign rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);
    assign arready_d = ~rvalid_d;
    assign rdata_d = ar_take ? (rd_ctrl_hit ? ctrl_word
                              : rd_stat_hit ? status_word : 32'h0)
                             : rdata_q;
    assign rresp_d = ar_take ? ((rd_ctrl_hit | rd_stat_hit)
                               ? sptr_pkg::RESP_OKAY : sptr_pkg::RESP_SLVERR)
                             : rresp_q;

    // One read in flight: the address channel waits for the data beat
    AST_RD_READY_LOW: assert property (@(posedge aclk)
        disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read address ready while data is pending");
    AST_READ_LATENCY: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ar_take |=> s_axi_rvalid)
        else $error("read data did not follow the address");
    AST_RDATA_HOLD: assert property (@(posedge aclk)
        disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
            && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data changed before it was taken");
    AST_RD_UNMAPPED: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ar_take && !rd_ctrl_hit && !rd_stat_hit
        |=> s_axi_rdata == 32'h0 && s_axi_rresp == sptr_pkg::RESP_SLVERR)
        else $error("unmapped read not answered with an error");

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= sptr_pkg::RESP_OKAY;
        end else begin
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_q <= 32'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_take) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= sptr_pkg::RESP_OKAY;
        end else begin
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= sptr_pkg::CTRL_RESET;
            step_prev_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            step_prev_q <= ctrl_q.step;
        end
    end

    sptr_translator u_translator (
        .aclk(aclk),
        .aresetn(aresetn),
        .step_pulse(step_pulse),
        .ctrl(ctrl_q),
        .state_q(state_q),
        .drive_q(drive_q)
    );

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign winding_drive_1 = drive_q.winding[3];
    assign winding_drive_2 = drive_q.winding[2];
    assign winding_drive_3 = drive_q.winding[1];
    assign winding_drive_4 = drive_q.winding[0];
    assign bridge_gate_1 = drive_q.bridge_gate[1];
    assign bridge_gate_2 = drive_q.bridge_gate[0];
    assign home_flag = drive_q.home;
    assign ref_reduced = drive_q.ref_reduced;

    AST_PULLUP_RESET: assert property (@(posedge aclk)
        $rose(aresetn) |-> ctrl_q.torque_comp_select)
        else $error("compensation select not high after reset");
    AST_ONE_STEP_PER_EDGE: assert property (@(posedge aclk)
        disable iff (!aresetn)
        step_pulse |=> !step_pulse)
        else $error("step strobe lasted more than one cycle");
    AST_HOME_PINS: assert property (@(posedge aclk)
        disable iff (!aresetn)
        home_flag && ctrl_q.enable && $past(ctrl_q.enable)
        |-> {winding_drive_1, winding_drive_2, winding_drive_3,
             winding_drive_4} == 4'h5)
        else $error("home flag high away from 0101");
    AST_WRITE_RESP: assert property (@(posedge aclk)
        disable iff (!aresetn)
        wr_fire |=> s_axi_bvalid)
        else $error("write response missing");
endmodule : sptr_top
`default_nettype wire

// ---- sptr_translator.sv ----
// Phase sequencer: modulo-eight state, winding patterns, reference select.
// Assumes step_pulse is a one-cycle strobe from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sptr_translator (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic step_pulse,
    input wire sptr_pkg::sptr_ctrl_t ctrl,
    output logic [2:0] state_q,
    output sptr_pkg::sptr_drive_t drive_q
);
    logic [2:0] stride;
    logic [2:0] state_step;
    logic [2:0] state_d;
    logic [3:0] pattern_d;
    logic home_d;
    logic reduced_d;
    sptr_pkg::sptr_drive_t drive_d;

    // Full step keeps parity, so wave or normal drive follows the state
    assign stride = ctrl.half_select ? sptr_pkg::HALF_STRIDE
                                     : sptr_pkg::FULL_STRIDE;
    assign state_step = ctrl.direction_select ? state_q + stride
                                              : state_q - stride;
    assign state_d = ctrl.seq_reset ? sptr_pkg::HOME_STATE
                   : step_pulse ? state_step : state_q;
    assign pattern_d = sptr_pkg::phase_pattern(state_d);
    assign home_d = (pattern_d == sptr_pkg::HOME_PATTERN);
    // Even index is a two-winding state; reduced only in half step
    assign reduced_d = ctrl.half_select & ctrl.torque_comp_select
                     & ~state_d[0];
    // Single driver for the whole carrier
    assign drive_d = '{ref_reduced: reduced_d, home: home_d,
                       bridge_gate: ctrl.enable ? 2'h3 : 2'h0,
                       winding: ctrl.enable ? pattern_d : 4'h0};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= sptr_pkg::HOME_STATE;
            drive_q <= '{ref_reduced: 1'b0, home: 1'b1, bridge_gate: 2'h3,
                         winding: sptr_pkg::HOME_PATTERN};
        end else begin
            state_q <= state_d;
            drive_q <= drive_d;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_half_fwd_step;
        step_pulse && ctrl.half_select && ctrl.direction_select
            && !ctrl.seq_reset;
    endsequence
    sequence s_half_rev_step;
        step_pulse && ctrl.half_select && !ctrl.direction_select
            && !ctrl.seq_reset;
    endsequence

    AST_NO_STEP_HOLD: assert property (
        !step_pulse && !ctrl.seq_reset |=> $stable(state_q))
        else $error("state moved without a step");
    AST_HALF_FWD: assert property (
        s_half_fwd_step |=> state_q == $past(state_q) + 3'h1)
        else $error("forward half step did not advance by one");
    AST_HALF_REV: assert property (
        s_half_rev_step |=> state_q == $past(state_q) - 3'h1)
        else $error("reverse half step did not go back by one");
    AST_FULL_PARITY: assert property (
        step_pulse && !ctrl.half_select && !ctrl.seq_reset
        |=> state_q[0] == $past(state_q[0])
            && state_q != $past(state_q))
        else $error("full step lost parity or did not move");
    AST_SEQ_RESET: assert property (
        ctrl.seq_reset && ctrl.enable
        |=> state_q == 3'h0 && drive_q.winding == 4'h5)
        else $error("sequence reset did not reach home");
    AST_HOME_FLAG: assert property (
        ##1 drive_q.home == (state_q == 3'h0))
        else $error("home flag disagrees with state");
    AST_DISABLED_LOW: assert property (
        !ctrl.enable |=> drive_q.winding == 4'h0
            && drive_q.bridge_gate == 2'h0)
        else $error("outputs not low while disabled");
    AST_FULL_REF: assert property (
        !ctrl.half_select |=> !drive_q.ref_reduced)
        else $error("reduced reference in full step");
    AST_COMP_REF: assert property (
        ctrl.half_select && ctrl.torque_comp_select
        |=> drive_q.ref_reduced == !state_q[0]
            && (!$past(ctrl.enable) || drive_q.ref_reduced
                == ($countones(drive_q.winding) == 2)))
        else $error("compensated reference on wrong state");
    AST_HALF_ALT: assert property (
        s_half_fwd_step ##0 ctrl.enable ##1 ctrl.enable
        |-> $countones(drive_q.winding)
            != $countones($past(drive_q.winding)))
        else $error("half step did not alternate winding count");
endmodule : sptr_translator
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench: AXI4-Lite master tasks drive the translator.
// Assumes the register map and latencies given with the translator.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic aclk, aresetn;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, coils_on, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, home_flag, ref_reduced, shoot_through;
    logic winding_drive_1, winding_drive_2, winding_drive_3, winding_drive_4;
    logic bridge_gate_1, bridge_gate_2;
    int err_total, num_checks;
    logic [2:0] idx;
    logic [5:0] cb;
    logic [31:0] rd;
    logic [3:0] pat [0:7] = '{4'h5, 4'h1, 4'h9, 4'h8, 4'ha, 4'h2, 4'h6, 4'h4};

    sptr_top u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .winding_drive_1(winding_drive_1), .winding_drive_2(winding_drive_2),
        .winding_drive_3(winding_drive_3), .winding_drive_4(winding_drive_4),
        .bridge_gate_1(bridge_gate_1), .bridge_gate_2(bridge_gate_2),
        .home_flag(home_flag), .ref_reduced(ref_reduced)
    );

    sptr_motor_model u_motor (
        .winding({winding_drive_1, winding_drive_2, winding_drive_3,
            winding_drive_4}),
        .bridge_gate({bridge_gate_1, bridge_gate_2}),
        .coils_on(coils_on), .shoot_through(shoot_through)
    );

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic tally_and_finish;
        $display("Counts: %0d checks, %0d mismatches", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
                             output logic [1:0] r);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_write

    task automatic axi_read(input logic [31:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_read

    // Status word expected for state i under control bits c
    function automatic logic [31:0] exp_stat(input logic [2:0] i,
                                             input logic [5:0] c);
        return {21'h0, c[2] & c[3] & ~i[0], i == 3'h0, {2{c[0]}},
            pat[i] & {4{c[0]}}, i};
    endfunction : exp_stat

    task automatic verify(input string what);
        logic [31:0] e;
        logic [1:0] ec;
        e = exp_stat(idx, cb);
        ec = cb[0] ? (idx[0] ? 2'h1 : 2'h2) : 2'h0;
        axi_read(sptr_pkg::STATUS_OFFSET, rd, resp);
        chk({what, " status"}, e, rd);
        chk({what, " pins"}, {24'h0, e[10:3]}, {24'h0, ref_reduced, home_flag,
            bridge_gate_1, bridge_gate_2, winding_drive_1, winding_drive_2,
            winding_drive_3, winding_drive_4});
        chk({what, " coils"}, {30'h0, ec}, {30'h0, coils_on});
        chk({what, " short"}, 32'h0, {31'h0, shoot_through});
    endtask : verify

    task automatic set_ctrl(input logic [5:0] c);
        cb = c;
        if (c[4])
            idx = 3'h0;
        axi_write(sptr_pkg::CTRL_OFFSET, {26'h0, c}, resp);
        chk("ctrl resp", {30'h0, sptr_pkg::RESP_OKAY}, {30'h0, resp});
        repeat (3) @(posedge aclk);
        verify("mode");
    endtask : set_ctrl

    // Second strobe write keeps step high, so no new rising edge
    task automatic step_once(input bit twice);
        axi_write(sptr_pkg::CTRL_OFFSET, {26'h0, cb | 6'h20}, resp);
        if (twice)
            axi_write(sptr_pkg::CTRL_OFFSET, {26'h0, cb | 6'h20}, resp);
        repeat (3) @(posedge aclk);
        if (!cb[4])
            idx = cb[1] ? idx + (cb[2] ? 3'h1 : 3'h2)
                : idx - (cb[2] ? 3'h1 : 3'h2);
        axi_write(sptr_pkg::CTRL_OFFSET, {26'h0, cb}, resp);
        repeat (3) @(posedge aclk);
        verify("step");
    endtask : step_once

    initial begin
        #(20 * 30000);
        err_total++;
        $display("Watchdog expired");
        tally_and_finish();
    end

    initial begin
        err_total = 0;
        num_checks = 0;
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {s_axi_awprot, s_axi_arprot} = '0;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        idx = 3'h0;
        cb = 6'h0b;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        verify("reset");
        axi_read(sptr_pkg::CTRL_OFFSET, rd, resp);
        chk("ctrl reset", 32'h0000_000b, rd);
        $display("Test reset done");
        set_ctrl(6'h0f);
        repeat (8) step_once(1'b0);
        $display("Test half forward done");
        set_ctrl(6'h0d);
        repeat (3) step_once(1'b0);
        $display("Test half reverse done");
        set_ctrl(6'h0b);
        repeat (4) step_once(1'b0);
        set_ctrl(6'h0f);
        step_once(1'b0);
        set_ctrl(6'h0b);
        repeat (4) step_once(1'b0);
        set_ctrl(6'h09);
        repeat (2) step_once(1'b0);
        $display("Test full step done");
        set_ctrl(6'h0e);
        step_once(1'b0);
        set_ctrl(6'h0f);
        step_once(1'b1);
        set_ctrl(6'h1f);
        step_once(1'b0);
        set_ctrl(6'h0f);
        $display("Test enable, strobe and reset done");
        axi_write(32'h0000_0008, 32'h0000_0000, resp);
        chk("unmapped wr", {30'h0, sptr_pkg::RESP_SLVERR}, {30'h0, resp});
        axi_write(sptr_pkg::STATUS_OFFSET, 32'hffff_ffff, resp);
        chk("status wr", {30'h0, sptr_pkg::RESP_SLVERR}, {30'h0, resp});
        s_axi_wstrb <= 4'he;
        axi_write(sptr_pkg::CTRL_OFFSET, 32'h0000_0000, resp);
        chk("strobe wr", {30'h0, sptr_pkg::RESP_OKAY}, {30'h0, resp});
        s_axi_wstrb <= 4'hf;
        axi_read(sptr_pkg::CTRL_OFFSET, rd, resp);
        chk("ctrl kept", 32'h0000_000f, rd);
        axi_read(32'h0000_0008, rd, resp);
        chk("unmapped rd", 32'h0, rd);
        chk("unmapped rresp", {30'h0, sptr_pkg::RESP_SLVERR}, {30'h0, resp});
        verify("after errors");
        $display("Test bus errors done");
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
